// ==== verilog/ifrz_pkg.sv ====
// Constants and types for the instruction freeze timing block
package ifrz_pkg;
	localparam int unsigned CNT_W   = 6;
	localparam int unsigned ACK_W   = 5;
	localparam int unsigned REG_W   = 5;
	localparam int unsigned SPACE_W = 4;
	localparam int unsigned LINE_W  = 4;

	// Fixed stall clocks
	localparam logic [CNT_W-1:0] NO_CLKS       = 6'h00;
	localparam logic [CNT_W-1:0] ONE_CLK       = 6'h01;
	localparam logic [CNT_W-1:0] TLB_BASE_CLKS = 6'h05;
	localparam logic [CNT_W-1:0] SFP_CLKS      = 6'h02;
	localparam logic [CNT_W-1:0] SFP_DD_CLKS   = 6'h03;
	localparam logic [CNT_W-1:0] SFP_EXTRA     = 6'h01;
	localparam logic [CNT_W-1:0] DC_MISS_CLKS  = 6'h02;
	localparam logic [CNT_W-1:0] DC_HIT_CLKS   = 6'h01;

	// Acknowledgement counts on the bus
	localparam logic [ACK_W-1:0] NO_ACKS        = 5'h00;
	localparam logic [ACK_W-1:0] FIRST_ACK      = 5'h01;
	localparam logic [ACK_W-1:0] TLB_READ_ACKS  = 5'h02;
	localparam logic [ACK_W-1:0] WR_SMALL_ACKS  = 5'h01;
	localparam logic [ACK_W-1:0] WR_WIDE_ACKS   = 5'h02;

	localparam logic [SPACE_W-1:0] SPACE_ZERO   = 4'h0;
	localparam logic [SPACE_W-1:0] SPACE_ONE    = 4'h1;
	localparam logic [SPACE_W-1:0] SPACE_MAX    = 4'hf;

	localparam logic [REG_W-1:0] ZERO_FP_REGISTER = 5'h00;

	typedef enum logic [1:0] {IFRZ_IDLE, IFRZ_FIXED, IFRZ_BUS} ifrz_state_t;
endpackage

// ==== verilog/ifrz_core.sv ====
// Instruction freeze and stall timing for the issue stage
`timescale 1ns/1ns
`default_nettype none
module ifrz_core
(
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          issue_valid,
	input  wire logic                          dual_mode,
	input  wire logic                          variant_first,
	input  wire logic                          dep_start,
	input  wire logic                          dep_valid,
	input  wire logic [ifrz_pkg::SPACE_W-1:0]  dep_min,
	input  wire logic                          sfp_start,
	input  wire logic                          sfp_recip,
	input  wire logic                          sfp_dd,
	input  wire logic [ifrz_pkg::REG_W-1:0]    sfp_dest_reg,
	input  wire logic                          sfp_dest_dbl,
	input  wire logic                          fp_use,
	input  wire logic [ifrz_pkg::REG_W-1:0]    fp_src_reg,
	input  wire logic                          fp_src_dbl,
	input  wire logic                          fp_pipelined,
	input  wire logic [ifrz_pkg::REG_W-1:0]    fp_dest_reg,
	input  wire logic                          tlb_miss,
	input  wire logic [1:0]                    abit_acks,
	input  wire logic                          icache_miss,
	input  wire logic                          line_has_freeze,
	input  wire logic [ifrz_pkg::LINE_W-1:0]   line_acks,
	input  wire logic                          dcache_busy,
	input  wire logic                          dcache_miss,
	input  wire logic                          write_stall,
	input  wire logic                          write_wide,
	input  wire logic                          path_full,
	input  wire logic                          bus_addr_repeat,
	input  wire logic                          address_strobe_n,
	input  wire logic                          burst_ack_n,
	output logic                               issue_hold,
	output logic                               instr_done
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

logic as_m;
logic as_s;
logic ack_m;
logic ack_s;
logic rep_d1;
logic rep_d2;
logic strobe;
logic ack;

always_ff @(posedge clk)
begin
	if (!resetn)
	begin
		as_m   <= 1'b1;
		as_s   <= 1'b1;
		ack_m  <= 1'b1;
		ack_s  <= 1'b1;
		rep_d1 <= 1'b0;
		rep_d2 <= 1'b0;
	end
	else
	begin
		as_m   <= address_strobe_n;
		as_s   <= as_m;
		ack_m  <= burst_ack_n;
		ack_s  <= ack_m;
		// Keeps the repeat flag aligned with the synchronised strobe
		rep_d1 <= bus_addr_repeat;
		rep_d2 <= rep_d1;
	end
end

assign strobe = !as_s;
assign ack    = !ack_s;

////////////////////////////////////////////////////////////////////////////////
// Spacing between dependent instructions

logic [ifrz_pkg::SPACE_W-1:0] elapsed;
logic [ifrz_pkg::SPACE_W-1:0] next_elapsed;
logic [ifrz_pkg::CNT_W-1:0]   space_stall;

always_comb
begin
	next_elapsed = elapsed;
	if (dep_start)
		next_elapsed = ifrz_pkg::SPACE_ZERO;
	else if (elapsed != ifrz_pkg::SPACE_MAX)
		next_elapsed = elapsed + ifrz_pkg::SPACE_ONE;
	space_stall = ifrz_pkg::NO_CLKS;
	if (dep_valid && dep_min > elapsed)
		space_stall = {2'h0, dep_min - elapsed};
end

always_ff @(posedge clk)
begin
	if (!resetn)
		elapsed <= ifrz_pkg::SPACE_MAX;
	else
		elapsed <= next_elapsed;
end

////////////////////////////////////////////////////////////////////////////////
// Scalar floating-point operation in progress

logic [ifrz_pkg::CNT_W-1:0] sfp_left;
logic [ifrz_pkg::CNT_W-1:0] next_sfp_left;
logic [ifrz_pkg::REG_W-1:0] sfp_reg;
logic [ifrz_pkg::REG_W-1:0] next_sfp_reg;
logic                       sfp_dbl;
logic                       next_sfp_dbl;
logic                       fp_extra;
logic [ifrz_pkg::CNT_W-1:0] fp_wait;

always_comb
begin
	next_sfp_left = sfp_left;
	next_sfp_reg  = sfp_reg;
	next_sfp_dbl  = sfp_dbl;
	if (sfp_start && !sfp_recip)
	begin
		next_sfp_left = sfp_dd ? ifrz_pkg::SFP_DD_CLKS : ifrz_pkg::SFP_CLKS;
		next_sfp_reg  = sfp_dest_reg;
		next_sfp_dbl  = sfp_dest_dbl;
	end
	else if (sfp_left != ifrz_pkg::NO_CLKS)
		next_sfp_left = sfp_left - ifrz_pkg::ONE_CLK;
	// Either situation adds the same single clock
	fp_extra = ((sfp_reg == fp_src_reg) && (sfp_dbl != fp_src_dbl))
		|| (fp_pipelined && (fp_dest_reg != ifrz_pkg::ZERO_FP_REGISTER));
	fp_wait = ifrz_pkg::NO_CLKS;
	if (fp_use && sfp_left != ifrz_pkg::NO_CLKS)
		fp_wait = sfp_left + (fp_extra ? ifrz_pkg::SFP_EXTRA : ifrz_pkg::NO_CLKS);
end

always_ff @(posedge clk)
begin
	if (!resetn)
	begin
		sfp_left <= ifrz_pkg::NO_CLKS;
		sfp_reg  <= ifrz_pkg::ZERO_FP_REGISTER;
		sfp_dbl  <= 1'b0;
	end
	else
	begin
		sfp_left <= next_sfp_left;
		sfp_reg  <= next_sfp_reg;
		sfp_dbl  <= next_sfp_dbl;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Freeze sequencer

ifrz_pkg::ifrz_state_t state;
ifrz_pkg::ifrz_state_t next_state;
logic [ifrz_pkg::CNT_W-1:0] fix_cnt;
logic [ifrz_pkg::CNT_W-1:0] next_fix_cnt;
logic [ifrz_pkg::ACK_W-1:0] ack_need;
logic [ifrz_pkg::ACK_W-1:0] next_ack_need;
logic                       rn_wait;
logic                       next_rn_wait;
logic                       seen;
logic                       next_seen;
logic                       next_issue_hold;
logic                       next_instr_done;
logic [ifrz_pkg::CNT_W-1:0] slot_total;
logic [ifrz_pkg::CNT_W-1:0] dc_clks;
logic [ifrz_pkg::CNT_W-1:0] fix_total;
logic [ifrz_pkg::ACK_W-1:0] need_total;
logic                       rn_req;

always_comb
begin
	// Pair takes the slower slot; one instruction sums its causes
	if (dual_mode)
		slot_total = (space_stall > fp_wait) ? space_stall : fp_wait;
	else
		slot_total = space_stall + fp_wait;
	dc_clks = ifrz_pkg::NO_CLKS;
	if (icache_miss && dcache_busy)
		dc_clks = dcache_miss ? ifrz_pkg::DC_MISS_CLKS : ifrz_pkg::DC_HIT_CLKS;
	fix_total = slot_total + dc_clks + (tlb_miss ? ifrz_pkg::TLB_BASE_CLKS : ifrz_pkg::NO_CLKS);
	need_total = ifrz_pkg::NO_ACKS;
	if (icache_miss)
		need_total = (variant_first && line_has_freeze) ? {1'b0, line_acks} : ifrz_pkg::FIRST_ACK;
	if (tlb_miss)
		need_total = need_total + ifrz_pkg::TLB_READ_ACKS + {3'h0, abit_acks};
	if (write_stall)
		need_total = need_total + (write_wide ? ifrz_pkg::WR_WIDE_ACKS : ifrz_pkg::WR_SMALL_ACKS);
	if (path_full && !variant_first)
		need_total = need_total + ifrz_pkg::FIRST_ACK;
	rn_req = path_full && variant_first;

	next_state      = state;
	next_fix_cnt    = fix_cnt;
	next_ack_need   = ack_need;
	next_rn_wait    = rn_wait;
	next_seen       = seen;
	next_instr_done = 1'b0;
	unique case (state)
		ifrz_pkg::IFRZ_IDLE:
		begin
			if (issue_valid)
			begin
				next_fix_cnt  = fix_total;
				next_ack_need = need_total;
				next_rn_wait  = rn_req;
				next_seen     = 1'b0;
				if (fix_total != ifrz_pkg::NO_CLKS)
					next_state = ifrz_pkg::IFRZ_FIXED;
				else if (need_total != ifrz_pkg::NO_ACKS || rn_req)
					next_state = ifrz_pkg::IFRZ_BUS;
				else
					next_instr_done = 1'b1;
			end
		end
		ifrz_pkg::IFRZ_FIXED:
		begin
			next_fix_cnt = fix_cnt - ifrz_pkg::ONE_CLK;
			if (fix_cnt == ifrz_pkg::ONE_CLK)
			begin
				if (ack_need != ifrz_pkg::NO_ACKS || rn_wait)
					next_state = ifrz_pkg::IFRZ_BUS;
				else
				begin
					next_state      = ifrz_pkg::IFRZ_IDLE;
					next_instr_done = 1'b1;
				end
			end
		end
		ifrz_pkg::IFRZ_BUS:
		begin
			if (strobe)
				next_seen = 1'b1;
			if (rn_wait && strobe && !rep_d2)
				next_rn_wait = 1'b0;
			if (ack_need != ifrz_pkg::NO_ACKS && (seen || strobe) && ack)
				next_ack_need = ack_need - ifrz_pkg::FIRST_ACK;
			if (!next_rn_wait && next_ack_need == ifrz_pkg::NO_ACKS)
			begin
				next_state      = ifrz_pkg::IFRZ_IDLE;
				next_instr_done = 1'b1;
			end
		end
	endcase
	next_issue_hold = (next_state != ifrz_pkg::IFRZ_IDLE);
end

always_ff @(posedge clk)
begin
	if (!resetn)
	begin
		state      <= ifrz_pkg::IFRZ_IDLE;
		fix_cnt    <= ifrz_pkg::NO_CLKS;
		ack_need   <= ifrz_pkg::NO_ACKS;
		rn_wait    <= 1'b0;
		seen       <= 1'b0;
		issue_hold <= 1'b0;
		instr_done <= 1'b0;
	end
	else
	begin
		state      <= next_state;
		fix_cnt    <= next_fix_cnt;
		ack_need   <= next_ack_need;
		rn_wait    <= next_rn_wait;
		seen       <= next_seen;
		issue_hold <= next_issue_hold;
		instr_done <= next_instr_done;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Checks

default clocking cb @(posedge clk); endclocking
default disable iff (!resetn);

logic accept;
assign accept = (state == ifrz_pkg::IFRZ_IDLE) && issue_valid;

sequence s_fixed_last;
	state == ifrz_pkg::IFRZ_FIXED && fix_cnt == ifrz_pkg::ONE_CLK && ack_need == ifrz_pkg::NO_ACKS && !rn_wait;
endsequence
sequence s_release;
	state == ifrz_pkg::IFRZ_IDLE && instr_done && !issue_hold;
endsequence

property p_one_clock;
	accept && fix_total == ifrz_pkg::NO_CLKS && need_total == ifrz_pkg::NO_ACKS && !rn_req |=> s_release;
endproperty
a_one_clock: assert property (p_one_clock) else $error("free instruction not done in one clock");

property p_spacing;
	dep_valid |-> (dep_min <= elapsed) == (space_stall == ifrz_pkg::NO_CLKS);
endproperty
a_spacing: assert property (p_spacing) else $error("spacing stall wrong");

property p_sfp_dd;
	sfp_start && !sfp_recip && sfp_dd |=> sfp_left == ifrz_pkg::SFP_DD_CLKS ##1 sfp_left == ifrz_pkg::SFP_CLKS;
endproperty
a_sfp_dd: assert property (p_sfp_dd) else $error("double multiply wait wrong");

property p_extra_once;
	fp_use && sfp_left != ifrz_pkg::NO_CLKS && fp_pipelined && fp_dest_reg != ifrz_pkg::ZERO_FP_REGISTER
		|-> fp_wait == sfp_left + ifrz_pkg::SFP_EXTRA;
endproperty
a_extra_once: assert property (p_extra_once) else $error("extra fp clock wrong");

property p_tlb_base;
	accept && tlb_miss && slot_total == ifrz_pkg::NO_CLKS && !icache_miss |=> fix_cnt == ifrz_pkg::TLB_BASE_CLKS;
endproperty
a_tlb_base: assert property (p_tlb_base) else $error("tlb base stall wrong");

property p_dcache;
	accept && icache_miss && dcache_busy && dcache_miss && !tlb_miss && slot_total == ifrz_pkg::NO_CLKS
		|=> fix_cnt == ifrz_pkg::DC_MISS_CLKS;
endproperty
a_dcache: assert property (p_dcache) else $error("data cache stall wrong");

property p_dual_max;
	dual_mode |-> slot_total == ((space_stall > fp_wait) ? space_stall : fp_wait);
endproperty
a_dual_max: assert property (p_dual_max) else $error("pair not the slower");

property p_last_ack;
	state == ifrz_pkg::IFRZ_BUS && !rn_wait && ack_need == ifrz_pkg::FIRST_ACK && (seen || strobe) && ack |=> s_release;
endproperty
a_last_ack: assert property (p_last_ack) else $error("not released at last ack");

property p_fixed_end;
	s_fixed_last |=> s_release;
endproperty
a_fixed_end: assert property (p_fixed_end) else $error("fixed stall did not end");

property p_hold_track;
	accept && fix_total != ifrz_pkg::NO_CLKS |=> issue_hold && !instr_done;
endproperty
a_hold_track: assert property (p_hold_track) else $error("hold missing");

endmodule
`default_nettype wire

// ==== verif/ifrz_bus_model.sv ====
// Behavioural external bus that answers with one strobe and a run of acks
`timescale 1ns/1ns
`default_nettype none
module ifrz_bus_model
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [3:0] gap,
	input  wire logic [3:0] acks,
	input  wire logic       rep,
	output var logic        address_strobe_n,
	output var logic        burst_ack_n,
	output var logic        bus_addr_repeat
);
	initial
	begin
		address_strobe_n = 1'b1;
		burst_ack_n = 1'b1;
		bus_addr_repeat = 1'b1;
	end
	// Strobe for one cycle, idle gap, then back to back acks
	always
	begin
		@(posedge clk);
		if (go)
		begin
			@(negedge clk);
			address_strobe_n = 1'b0;
			bus_addr_repeat = rep;
			@(negedge clk);
			address_strobe_n = 1'b1;
			bus_addr_repeat = ~rep;
			repeat (gap) @(negedge clk);
			repeat (acks)
			begin
				burst_ack_n = 1'b0;
				@(negedge clk);
			end
			burst_ack_n = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== verif/instruction_freeze_timing_test.sv ====
// Self-checking bench for the instruction freeze timing block
`timescale 1ns/1ns
`default_nettype none
module instruction_freeze_timing_test;
	logic                         clk, resetn, issue_valid, dual_mode, variant_first, dep_start, dep_valid;
	logic [ifrz_pkg::SPACE_W-1:0] dep_min;
	logic                         sfp_start, sfp_recip, sfp_dd, sfp_dest_dbl, fp_use, fp_src_dbl, fp_pipelined;
	logic [ifrz_pkg::REG_W-1:0]   sfp_dest_reg, fp_src_reg, fp_dest_reg;
	logic                         tlb_miss, icache_miss, line_has_freeze, dcache_busy, dcache_miss;
	logic [1:0]                   abit_acks;
	logic [ifrz_pkg::LINE_W-1:0]  line_acks;
	logic                         write_stall, write_wide, path_full, go, rep;
	logic [3:0]                   gap, acks;
	wire logic                    address_strobe_n, burst_ack_n, bus_addr_repeat, issue_hold, instr_done;
	int                           bad_count, check_count, cycles;
	int                           sp_k[3] = '{1, 4, 5};
	int                           sp_e[3] = '{5, 2, 1};
	logic [4:0]                   sf_c[7] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h0c, 5'h02, 5'h01};
	int                           sf_e[7] = '{3, 4, 4, 4, 4, 3, 1};

	ifrz_core ifrz_core_i (.clk, .resetn, .issue_valid, .dual_mode, .variant_first, .dep_start, .dep_valid,
		.dep_min, .sfp_start, .sfp_recip, .sfp_dd, .sfp_dest_reg, .sfp_dest_dbl, .fp_use, .fp_src_reg,
		.fp_src_dbl, .fp_pipelined, .fp_dest_reg, .tlb_miss, .abit_acks, .icache_miss, .line_has_freeze,
		.line_acks, .dcache_busy, .dcache_miss, .write_stall, .write_wide, .path_full, .bus_addr_repeat,
		.address_strobe_n, .burst_ack_n, .issue_hold, .instr_done);
	ifrz_bus_model ifrz_bus_model_i (.clk, .go, .gap, .acks, .rep, .address_strobe_n, .burst_ack_n,
		.bus_addr_repeat);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check_int(input string name, input int exp, input int seen);
		check_count++;
		if (exp != seen)
		begin
			bad_count++;
			$display("mismatch %s expected %0d seen %0d", name, exp, seen);
		end
	endtask
	task automatic check_bit(input string name, input logic exp, input logic seen);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task automatic clear();
		{issue_valid, dual_mode, variant_first, dep_start, dep_valid, dep_min, sfp_start, sfp_recip, sfp_dd} = '0;
		{sfp_dest_reg, sfp_dest_dbl, fp_use, fp_src_reg, fp_src_dbl, fp_pipelined, fp_dest_reg, tlb_miss} = '0;
		{abit_acks, icache_miss, line_has_freeze, line_acks, dcache_busy, dcache_miss, write_stall} = '0;
		{write_wide, path_full} = '0;
	endtask
	// Bus activity d cycles after the take: strobe, g idle cycles, n acks
	task automatic launch(input int d, input int g, input int n, input logic r);
		repeat (d) @(negedge clk);
		gap = 4'(g);
		acks = 4'(n);
		rep = r;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
	endtask
	// Issues one instruction and counts its clocks, the take cycle included
	task automatic run(input string name, input int exp, input int d, input int g, input int n, input logic r,
		input int d2);
		int cnt;
		cnt = 1;
		issue_valid = 1'b1;
		fork
			if (n > 0) launch(d, g, n, r);
			if (d2 > 0) launch(d2, 0, 0, 1'b0);
		join_none
		@(negedge clk);
		issue_valid = 1'b0;
		if (exp > 1) check_bit({name, " hold"}, 1'b1, issue_hold);
		while (instr_done !== 1'b1 && cnt < 100)
		begin
			@(negedge clk);
			cnt++;
		end
		check_int(name, exp, cnt);
		check_bit({name, " release"}, 1'b0, issue_hold);
		if (n > 0 || d2 > 0) repeat (8) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic spacing(input int k, input int exp);
		dep_start = 1'b1;
		@(negedge clk);
		dep_start = 1'b0;
		repeat (k - 1) @(negedge clk);
		dep_valid = 1'b1;
		dep_min = 4'h4;
		run("spacing", exp, 0, 0, 0, 1'b0, 0);
		clear();
	endtask
	task automatic scalar(input logic [4:0] c, input int exp);
		sfp_start = 1'b1;
		sfp_dd = c[4];
		sfp_recip = c[0];
		sfp_dest_reg = 5'h03;
		sfp_dest_dbl = 1'b1;
		@(negedge clk);
		sfp_start = 1'b0;
		fp_use = 1'b1;
		fp_src_reg = c[3] ? 5'h03 : 5'h04;
		fp_pipelined = c[2] | c[1];
		fp_dest_reg = c[2] ? 5'h07 : ifrz_pkg::ZERO_FP_REGISTER;
		run("scalar wait", exp, 0, 0, 0, 1'b0, 0);
		clear();
	endtask
	// Spacing stall of three and scalar wait of two on one instruction
	task automatic combo(input logic dual, input int exp);
		dual_mode = dual;
		dep_start = 1'b1;
		@(negedge clk);
		dep_start = 1'b0;
		sfp_start = 1'b1;
		sfp_dest_reg = 5'h03;
		@(negedge clk);
		{sfp_start, dep_valid, dep_min, fp_use, fp_src_reg} = {1'b0, 1'b1, 4'h4, 1'b1, 5'h04};
		run("combined", exp, 0, 0, 0, 1'b0, 0);
		clear();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{bad_count, check_count, cycles} = '0;
		{go, gap, acks, rep} = '0;
		clear();
		resetn = 1'b0;
		repeat (4) @(negedge clk);
		check_bit("reset hold", 1'b0, issue_hold);
		check_bit("reset done", 1'b0, instr_done);
		resetn = 1'b1;
		run("plain", 1, 0, 0, 0, 1'b0, 0);
		run("back to back", 1, 0, 0, 0, 1'b0, 0);
		@(negedge clk);
		check_bit("done pulse", 1'b0, instr_done);
		foreach (sp_k[i]) spacing(sp_k[i], sp_e[i]);
		foreach (sf_c[i]) scalar(sf_c[i], sf_e[i]);
		combo(1'b0, 6);
		combo(1'b1, 4);
		icache_miss = 1'b1;
		run("fetch miss", 7, 0, 2, 1, 1'b0, 0);
		{variant_first, line_has_freeze, line_acks} = {1'b1, 1'b1, 4'h4};
		run("line fill", 8, 0, 0, 4, 1'b0, 0);
		clear();
		{icache_miss, dcache_busy, dcache_miss} = 3'h7;
		run("fetch data miss", 9, 4, 0, 1, 1'b0, 0);
		clear();
		tlb_miss = 1'b1;
		for (int a = 0; a < 2; a++)
		begin
			abit_acks = 2'(a);
			run("tlb miss", 13 + a, 6, 1, 2 + a, 1'b0, 0);
		end
		clear();
		write_stall = 1'b1;
		run("small write", 6, 0, 1, 2, 1'b0, 0);
		write_wide = 1'b1;
		run("wide write", 7, 0, 1, 2, 1'b0, 0);
		clear();
		path_full = 1'b1;
		run("path full", 5, 0, 0, 1, 1'b0, 0);
		variant_first = 1'b1;
		run("new address", 10, 0, 0, 1, 1'b1, 6);
		clear();
		report_and_stop();
	end
endmodule
`default_nettype wire
